// File: pdr_regs.sv
// Purpose: direction, latch and pull-up registers of four ports, open-drain registers of three, analog of two
// Assumes: AXI4-Lite slave, one write and one read in flight, pins synchronous to aclk
// Notes: unmounted direction bits are tied to one, other unmounted bits to zero
// Functional notes
// - direction bit zero enables output driver
// - direction bit one makes pin input
// - one direction bit per pin
// - byte and single-bit writes, others kept
// - reset loads all direction registers with ones
// - mounted bits depend on package size
// - four direction registers at fixed addresses
// - data read gives pin in input mode
// - pull-up only on digital push-pull inputs
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module pdr_regs
	import pdr_pkg::*;
#(
	parameter int PKG_PINS = 20 // package variant: 8, 10, 16 or 20
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [NPORT-1:0][7:0] pin_in,
	input wire logic input_only_pin,
	output logic [NPORT-1:0][7:0] pin_out,
	output logic [NPORT-1:0][7:0] pin_oe_n,
	output logic [NPORT-1:0][7:0] pin_pullup_en
);

	// package-dependent masks, fixed at elaboration
	localparam logic [31:0] MNT = pdr_pick(PKG_PINS, MNT_20, MNT_16, MNT_10, MNT_8);
	localparam logic [31:0] POMM = pdr_pick(PKG_PINS, POM_20, POM_16, POM_10, POM_8);
	localparam logic [31:0] PMCM = pdr_pick(PKG_PINS, PMC_20, PMC_16, PMC_10, PMC_8);

	// register state
	logic [NPORT-1:0][7:0] dir_q; // pin_direction_bit per pin
	logic [NPORT-1:0][7:0] lat_q; // output latches
	logic [NPORT-1:0][7:0] pu_q; // pull-up select
	logic [NPORT-1:0][7:0] pom_q; // open-drain select
	logic [NPORT-1:0][7:0] pmc_q; // analog select
	logic [NPORT-1:0][7:0] next_dir_q;
	logic [NPORT-1:0][7:0] next_lat_q;
	logic [NPORT-1:0][7:0] next_pu_q;
	logic [NPORT-1:0][7:0] next_pom_q;
	logic [NPORT-1:0][7:0] next_pmc_q;

	// write channel state
	logic aw_got; // address held
	logic w_got; // data held
	logic [ADDR_W-1:0] aw_addr_q;
	logic [7:0] w_byte_q;
	logic w_lane_q; // low byte lane enabled
	logic next_aw_got;
	logic next_w_got;
	logic [ADDR_W-1:0] next_aw_addr_q;
	logic [7:0] next_w_byte_q;
	logic next_w_lane_q;
	logic next_awready;
	logic next_wready;
	logic next_bvalid;
	logic [1:0] next_bresp;

	// read channel state
	logic next_arready;
	logic next_rvalid;
	logic [DATA_W-1:0] next_rdata;
	logic [1:0] next_rresp;

	// decoded hits
	pdr_hit_s wr_hit;
	pdr_hit_s rd_hit;
	logic wr_do; // both halves of a write present

	// map a byte address to a register group and port slot
	function automatic pdr_hit_s addr_decode(input logic [ADDR_W-1:0] addr);
		pdr_hit_s h;
		logic [19:0] idx;
		h.kind = PDR_K_NONE;
		h.slot = 2'h0;
		idx = addr[ADDR_W-1:2];
		for (int p = 0; p < NPORT; p++) begin
			if (idx == DIR_IDX[p]) begin
				h.kind = PDR_K_DIR;
				h.slot = p[1:0];
			end
			if (idx == DATA_IDX[p]) begin
				h.kind = PDR_K_DATA;
				h.slot = p[1:0];
			end
			if (idx == PU_IDX[p]) begin
				h.kind = PDR_K_PU;
				h.slot = p[1:0];
			end
			if (p < 3 && idx == POM_IDX[p]) begin
				h.kind = PDR_K_POM;
				h.slot = p[1:0];
			end
			if (p < 2 && idx == PMC_IDX[p]) begin
				h.kind = PDR_K_PMC;
				h.slot = p[1:0];
			end
		end
		if (idx == IN_IDX) begin
			h.kind = PDR_K_IN;
		end
		if (idx == BIT_IDX) begin
			h.kind = PDR_K_BIT;
		end
		// misaligned addresses hit nothing
		if (addr[1:0] != 2'b00) begin
			h.kind = PDR_K_NONE;
		end
		return h;
	endfunction : addr_decode

	// masked write of a byte; unmounted bits take their fixed value
	function automatic logic [7:0] merge(input logic [7:0] val, input logic [7:0] mask,
			input logic [7:0] fixed);
		return (val & mask) | (fixed & ~mask);
	endfunction : merge

	assign wr_hit = addr_decode(aw_addr_q);
	assign rd_hit = addr_decode(araddr);
	assign wr_do = aw_got && w_got && !bvalid;

	// write handshake and register updates
	always_comb begin
		next_aw_got = aw_got;
		next_w_got = w_got;
		next_aw_addr_q = aw_addr_q;
		next_w_byte_q = w_byte_q;
		next_w_lane_q = w_lane_q;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_dir_q = dir_q;
		next_lat_q = lat_q;
		next_pu_q = pu_q;
		next_pom_q = pom_q;
		next_pmc_q = pmc_q;
		// address and data are taken in either order and held
		if (awvalid && awready) begin
			next_aw_got = 1'b1;
			next_aw_addr_q = awaddr;
		end
		if (wvalid && wready) begin
			next_w_got = 1'b1;
			next_w_byte_q = wdata[7:0];
			next_w_lane_q = wstrb[0];
		end
		if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
		if (wr_do) begin
			next_aw_got = 1'b0;
			next_w_got = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = RESP_OKAY;
			if (w_lane_q) begin
				unique case (wr_hit.kind)
					PDR_K_DIR: begin
						// whole-byte write, unmounted bits stay one
						next_dir_q[wr_hit.slot] = merge(w_byte_q, MNT[wr_hit.slot*8 +: 8],
							DIR_RESET);
					end
					PDR_K_DATA: begin
						next_lat_q[wr_hit.slot] = merge(w_byte_q, MNT[wr_hit.slot*8 +: 8],
							ZERO_BYTE);
					end
					PDR_K_PU: begin
						next_pu_q[wr_hit.slot] = merge(w_byte_q, MNT[wr_hit.slot*8 +: 8],
							ZERO_BYTE);
					end
					PDR_K_POM: begin
						next_pom_q[wr_hit.slot] = merge(w_byte_q, POMM[wr_hit.slot*8 +: 8],
							ZERO_BYTE);
					end
					PDR_K_PMC: begin
						next_pmc_q[wr_hit.slot] = merge(w_byte_q, PMCM[wr_hit.slot*8 +: 8],
							ZERO_BYTE);
					end
					PDR_K_BIT: begin
						// one direction bit changes, the rest of the byte is kept
						if (MNT[{w_byte_q[BIT_PORT_LSB +: 2], w_byte_q[BIT_SEL_LSB +: 3]}]) begin
							next_dir_q[w_byte_q[BIT_PORT_LSB +: 2]][w_byte_q[BIT_SEL_LSB +: 3]] =
								w_byte_q[BIT_VAL_POS];
						end
					end
					PDR_K_IN: begin
						// read-only register
						next_bresp = RESP_SLVERR;
					end
					PDR_K_NONE: begin
						next_bresp = RESP_SLVERR;
					end
				endcase
			end else if (wr_hit.kind == PDR_K_NONE) begin
				// empty strobe still reports an unmapped address
				next_bresp = RESP_SLVERR;
			end
		end
		next_awready = !next_aw_got;
		next_wready = !next_w_got;
	end

	// register the write side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr_q <= '0;
			w_byte_q <= ZERO_BYTE;
			w_lane_q <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			for (int p = 0; p < NPORT; p++) begin
				dir_q[p] <= DIR_RESET;
				lat_q[p] <= DATA_RESET;
				pu_q[p] <= PU_RESET[p*8 +: 8] & MNT[p*8 +: 8];
				pom_q[p] <= ZERO_BYTE;
				pmc_q[p] <= ZERO_BYTE;
			end
		end else begin
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			aw_addr_q <= next_aw_addr_q;
			w_byte_q <= next_w_byte_q;
			w_lane_q <= next_w_lane_q;
			awready <= next_awready;
			wready <= next_wready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			dir_q <= next_dir_q;
			lat_q <= next_lat_q;
			pu_q <= next_pu_q;
			pom_q <= next_pom_q;
			pmc_q <= next_pmc_q;
		end
	end

	// read decode and answer, registered one cycle after the address is taken
	always_comb begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (rvalid && rready) begin
			next_rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rresp = RESP_OKAY;
			next_rdata = '0;
			unique case (rd_hit.kind)
				PDR_K_DIR: begin
					next_rdata[7:0] = dir_q[rd_hit.slot];
				end
				PDR_K_DATA: begin
					// inputs show the pin, outputs the latch; analog inputs read zero
					next_rdata[7:0] = ((dir_q[rd_hit.slot] & pin_in[rd_hit.slot]) |
						(~dir_q[rd_hit.slot] & lat_q[rd_hit.slot])) &
						~(dir_q[rd_hit.slot] & pmc_q[rd_hit.slot]) &
						MNT[rd_hit.slot*8 +: 8];
				end
				PDR_K_PU: begin
					next_rdata[7:0] = pu_q[rd_hit.slot];
				end
				PDR_K_POM: begin
					next_rdata[7:0] = pom_q[rd_hit.slot];
				end
				PDR_K_PMC: begin
					next_rdata[7:0] = pmc_q[rd_hit.slot];
				end
				PDR_K_IN: begin
					next_rdata[IN_PIN_POS] = input_only_pin;
				end
				PDR_K_BIT: begin
					// write-only strobe reads as zero
					next_rdata = '0;
				end
				PDR_K_NONE: begin
					next_rresp = RESP_SLVERR;
				end
			endcase
		end
		next_arready = !next_rvalid;
	end

	// register the read side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else begin
			arready <= next_arready;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	// one pin bank per port; protection bits are not used by this slave
	for (genvar g = 0; g < NPORT; g++) begin : g_bank
		pdr_pin_bank u_bank (
			.aclk(aclk),
			.aresetn(aresetn),
			.dir(dir_q[g] | ~MNT[g*8 +: 8]),
			.latch(lat_q[g]),
			.pu_sel(pu_q[g]),
			.od_sel(pom_q[g]),
			.an_sel(pmc_q[g]),
			.pin_out(pin_out[g]),
			.pin_oe_n(pin_oe_n[g]),
			.pin_pullup_en(pin_pullup_en[g])
		);
	end

endmodule : pdr_regs

// File: pdr_pkg.sv
// Purpose: shared constants and types for the port direction register bank
// Assumes: 32-bit register bus, 8-bit registers in the low byte lane
// Notes: printed offsets are word indices; byte address is four times the index
package pdr_pkg;

	// bus geometry
	localparam int ADDR_W = 22;
	localparam int DATA_W = 32;
	localparam int NPORT = 4; // slots 0..3 stand for ports 0, 2, 4 and 12

	// word indices of each register group, highest slot first
	localparam logic [NPORT-1:0][19:0] DIR_IDX = {20'hfff2c, 20'hfff24, 20'hfff22, 20'hfff20};
	localparam logic [NPORT-1:0][19:0] DATA_IDX = {20'hfff0c, 20'hfff04, 20'hfff02, 20'hfff00};
	localparam logic [NPORT-1:0][19:0] PU_IDX = {20'hf003c, 20'hf0034, 20'hf0032, 20'hf0030};
	localparam logic [2:0][19:0] POM_IDX = {20'hf0054, 20'hf0052, 20'hf0050};
	localparam logic [1:0][19:0] PMC_IDX = {20'hf0062, 20'hf0060};
	localparam logic [19:0] IN_IDX = 20'hfff0d; // input-only pin data
	localparam logic [19:0] BIT_IDX = 20'hfff30; // single-bit direction write

	// single-bit write layout
	localparam int BIT_SEL_LSB = 0; // bits 2..0: bit number
	localparam int BIT_VAL_POS = 3; // bit 3: value to store
	localparam int BIT_PORT_LSB = 4; // bits 5..4: port slot

	// reset values
	localparam logic [7:0] DIR_RESET = 8'hff;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [31:0] PU_RESET = 32'h20010000;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam int IN_PIN_POS = 7;

	// mounted pins per package, bytes {p12, p4, p2, p0}
	localparam logic [31:0] MNT_20 = 32'h26030fff;
	localparam logic [31:0] MNT_16 = 32'h260300ff;
	localparam logic [31:0] MNT_10 = 32'h2001001f;
	localparam logic [31:0] MNT_8 = 32'h2001001a;
	// open-drain capable pins
	localparam logic [31:0] POM_20 = 32'h000204fb;
	localparam logic [31:0] POM_16 = 32'h000000fb;
	localparam logic [31:0] POM_10 = 32'h0000000b;
	localparam logic [31:0] POM_8 = 32'h0000000a;
	// pins with an analog function
	localparam logic [31:0] PMC_20 = 32'h00000ffe;
	localparam logic [31:0] PMC_16 = 32'h000000fe;
	localparam logic [31:0] PMC_10 = 32'h0000001e;
	localparam logic [31:0] PMC_8 = 32'h0000001a;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// register group hit by an address
	typedef enum logic [2:0] {
		PDR_K_DIR = 3'h0,
		PDR_K_DATA = 3'h1,
		PDR_K_PU = 3'h2,
		PDR_K_POM = 3'h3,
		PDR_K_PMC = 3'h4,
		PDR_K_IN = 3'h5,
		PDR_K_BIT = 3'h6,
		PDR_K_NONE = 3'h7
	} pdr_kind_e;

	typedef struct packed {
		pdr_kind_e kind;
		logic [1:0] slot;
	} pdr_hit_s;

	// pick a package variant's mask word
	function automatic logic [31:0] pdr_pick(input int pins, input logic [31:0] m20,
			input logic [31:0] m16, input logic [31:0] m10, input logic [31:0] m8);
		if (pins >= 20) begin
			return m20;
		end else if (pins >= 16) begin
			return m16;
		end else if (pins >= 10) begin
			return m10;
		end
		return m8;
	endfunction : pdr_pick

endpackage : pdr_pkg

// File: pdr_pin_bank.sv
// Purpose: pin drive, enable and pull-up control for one 8-bit port
// Assumes: all control inputs already masked to mounted pins
// Notes: every output is registered so the top drives pins from flops
`timescale 1ns/1ps
module pdr_pin_bank
	import pdr_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] dir, // 1 input, 0 output
	input wire logic [7:0] latch, // output latch
	input wire logic [7:0] pu_sel, // pull-up request
	input wire logic [7:0] od_sel, // open-drain request
	input wire logic [7:0] an_sel, // analog request
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe_n,
	output logic [7:0] pin_pullup_en
);

	logic [7:0] next_pin_out; // next drive level
	logic [7:0] next_pin_oe_n; // next enable, low drives
	logic [7:0] next_pin_pullup_en; // next pull-up state

	// per-pin output and pull-up decision
	always_comb begin
		next_pin_out = latch;
		// open drain releases the pin for a one, so it never drives high
		next_pin_oe_n = dir | (od_sel & latch);
		// pull-up only on a digital push-pull input
		next_pin_pullup_en = pu_sel & dir & ~an_sel & ~od_sel;
	end

	// register the pin controls; reset leaves every pin an undriven input
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out <= DATA_RESET;
			pin_oe_n <= DIR_RESET;
			pin_pullup_en <= ZERO_BYTE;
		end else begin
			pin_out <= next_pin_out;
			pin_oe_n <= next_pin_oe_n;
			pin_pullup_en <= next_pin_pullup_en;
		end
	end

endmodule : pdr_pin_bank

// File: pdr_properties.sv
// Purpose: port checks for the direction register bank
// Assumes: sees only top ports, one clock, reset held two cycles or more
// Notes: bound to pdr_regs by the bind after the module
`timescale 1ns/1ps
module pdr_properties
	import pdr_pkg::*;
#(
	parameter int PKG_PINS = 20 // package variant
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awready,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [NPORT-1:0][7:0] pin_oe_n,
	input wire logic [NPORT-1:0][7:0] pin_pullup_en
);
	// mounted bits of this variant
	localparam logic [31:0] MNT = pdr_pick(PKG_PINS, MNT_20, MNT_16, MNT_10, MNT_8);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// reset must not be disabled by itself
	rst_idle_a: assert property (disable iff (1'b0) !aresetn |=> !bvalid && !rvalid && !awready
		&& pin_oe_n == '1) else $error("outputs not idle after reset");
	unmounted_oe_a: assert property ((32'(pin_oe_n) | MNT) == 32'hffffffff)
		else $error("unmounted pin driven");
	oe_by_write_a: assert property ($changed(pin_oe_n) |-> $past(bvalid))
		else $error("pin drive changed without a write");
	pullup_input_a: assert property ((pin_pullup_en & ~pin_oe_n) == '0)
		else $error("pull-up on a driven pin");
	read_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	read_busy_a: assert property (rvalid |-> !arready) else $error("read taken while busy");
	read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	byte_wide_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	write_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	write_both_a: assert property ($rose(bvalid) |-> !$past(awready) && !$past(wready))
		else $error("response before both taken");
	// main scenarios reached
	cover property (bvalid && bready && bresp == RESP_SLVERR);
	cover property (rvalid && rready);
	cover property ($changed(pin_oe_n));
	cover property (pin_pullup_en[0] != 8'h00);
endmodule : pdr_properties

bind pdr_regs pdr_properties #(.PKG_PINS(PKG_PINS)) u_props (.aclk(aclk), .aresetn(aresetn),
	.awready(awready), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
	.pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en));

// File: pdr_regs_bench.sv
// Purpose: self-checking bench for the direction register bank
// Assumes: 20-pin variant, lfsr stimulus from a fixed start
// Notes: expectations come from the mounted masks, not from the design
`timescale 1ns/1ps
module pdr_regs_bench
	import pdr_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0;
	logic [ADDR_W-1:0] araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [DATA_W-1:0] wdata = '0;
	logic [3:0] wstrb = 4'h0;
	logic [NPORT-1:0][7:0] pin_in = '0; // pin levels
	logic input_only_pin = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [DATA_W-1:0] rdata;
	logic [NPORT-1:0][7:0] pin_out, pin_oe_n, pin_pullup_en;
	int err_count = 0;
	int checks_done = 0;
	logic [31:0] seed = 32'h0000002b; // lfsr state
	logic [7:0] exp_dir [NPORT]; // direction model
	logic [1:0] resp;
	logic [31:0] rd;
	logic [7:0] pv;
	logic [1:0] s;

	always #5 aclk = ~aclk;

	pdr_regs #(.PKG_PINS(20)) uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .pin_in(pin_in),
		.input_only_pin(input_only_pin), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pin_pullup_en(pin_pullup_en));

	// eight lfsr steps per draw
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		for (int i = 0; i < 8; i++) begin
			v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
		end
		return v;
	endfunction : lfsr

	// pull-ups expected from the select bytes and the direction model
	function automatic logic [31:0] pull_exp(input logic [7:0] pu0);
		return {PU_RESET[31:8], pu0} & MNT_20 & {exp_dir[3], exp_dir[2], exp_dir[1], exp_dir[0]};
	endfunction : pull_exp

	task automatic check_data(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check_data

	task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t response got %b exp %b", $time, got, exp);
		end
	endtask : check_resp

	// entered right after an edge; both channels offered together
	task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [7:0] d,
			input logic [3:0] st, output logic [1:0] r, input int lag = 0);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= (lag == 0);
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			// a late ready makes the response stand for a few cycles
			if (n == lag) bready <= 1'b1;
		end while (!(bvalid && bready) && n < 100);
		r = bresp;
		bready <= 1'b0;
		if (n >= 100) check_data(32'h1, 32'h0, "write timeout");
		@(posedge aclk); // keeps bready from two writes in one step
	endtask : axi_write

	task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d,
			output logic [1:0] r, input int lag = 0);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= (lag == 0);
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
			if (n == lag) rready <= 1'b1;
		end while (!(rvalid && rready) && n < 100);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n >= 100) check_data(32'h1, 32'h0, "read timeout");
		@(posedge aclk);
	endtask : axi_read

	// read all four registers and the pin enables
	task automatic check_dirs();
		for (int i = 0; i < NPORT; i++) begin
			axi_read({DIR_IDX[i], 2'b00}, rd, resp);
			check_resp(resp, RESP_OKAY);
			check_data(rd, {24'h0, exp_dir[i]}, "direction");
		end
		check_data(pin_oe_n, {exp_dir[3], exp_dir[2], exp_dir[1], exp_dir[0]}, "oe");
	endtask : check_dirs

	// synchronous reset, two edges low
	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		for (int i = 0; i < NPORT; i++) exp_dir[i] = DIR_RESET;
	endtask : do_reset

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict

	// hang guard, far beyond the expected run of about 750 cycles
	initial begin
		repeat (20000) @(posedge aclk);
		check_data(32'h1, 32'h0, "watchdog");
		give_verdict();
	end

	initial begin
		do_reset();
		check_data(pin_pullup_en, pull_exp(8'h00), "pull-up reset");
		check_dirs();
		$display("reset test done");
		// byte writes and single-bit writes mixed; first four clear each port
		for (int i = 0; i < 40; i++) begin
			seed = lfsr(seed);
			s = (i < 4) ? i[1:0] : seed[9:8];
			pv = (i < 4) ? 8'h00 : seed[7:0];
			if (i < 4 || seed[10]) begin
				// first four zero the unmounted bits too, to show they stay one
				if (i >= 4) pv = pv | ~MNT_20[8*s +: 8];
				axi_write({DIR_IDX[s], 2'b00}, pv, 4'h1, resp);
				exp_dir[s] = pv | ~MNT_20[8*s +: 8];
			end else begin
				axi_write({BIT_IDX, 2'b00}, {2'b00, s, pv[3:0]}, 4'h1, resp);
				if (MNT_20[8*s + pv[2:0]]) exp_dir[s][pv[2:0]] = pv[3];
			end
			check_resp(resp, RESP_OKAY);
			check_dirs();
		end
		$display("write test done");
		axi_write({DIR_IDX[0], 2'b00}, 8'h5a, 4'h0, resp);
		check_resp(resp, RESP_OKAY);
		axi_write(22'h000100, 8'h00, 4'h1, resp);
		check_resp(resp, RESP_SLVERR);
		axi_write({DIR_IDX[1], 2'b01}, 8'h00, 4'h1, resp);
		check_resp(resp, RESP_SLVERR);
		axi_read(22'h000100, rd, resp);
		check_resp(resp, RESP_SLVERR);
		// answers held while the master is slow to take them
		axi_write({DIR_IDX[2], 2'b00}, 8'hfe, 4'h1, resp, 3);
		check_resp(resp, RESP_OKAY);
		exp_dir[2] = 8'hfe;
		axi_read({DIR_IDX[2], 2'b00}, rd, resp, 4);
		check_data(rd, 32'h000000fe, "late ready read");
		check_dirs();
		$display("refusal test done");
		// mixed port: low nibble input, high nibble driven
		seed = lfsr(seed);
		pv = seed[7:0];
		pin_in[0] <= pv;
		axi_write({DIR_IDX[0], 2'b00}, 8'h0f, 4'h1, resp);
		exp_dir[0] = 8'h0f;
		axi_write({DATA_IDX[0], 2'b00}, 8'ha5, 4'h1, resp);
		axi_write({PU_IDX[0], 2'b00}, 8'hff, 4'h1, resp);
		axi_read({DATA_IDX[0], 2'b00}, rd, resp);
		check_data(rd, {24'h0, (pv & 8'h0f) | 8'ha0}, "pin data");
		check_data({24'h0, pin_out[0]}, 32'h000000a5, "latch");
		check_data(pin_pullup_en, pull_exp(8'hff), "pull-up");
		check_dirs();
		// bit1 analog, high nibble open drain; input-only pin read
		axi_write({PMC_IDX[0], 2'b00}, 8'h02, 4'h1, resp);
		axi_write({POM_IDX[0], 2'b00}, 8'hf0, 4'h1, resp);
		input_only_pin <= 1'b1;
		axi_read({DATA_IDX[0], 2'b00}, rd, resp);
		check_data(rd, {24'h0, (pv & 8'h0d) | 8'ha0}, "analog data");
		check_data({24'h0, pin_oe_n[0]}, 32'h000000af, "open drain");
		check_data({24'h0, pin_pullup_en[0]}, 32'h0000000d, "pull-up mode");
		axi_read({IN_IDX, 2'b00}, rd, resp);
		check_data(rd, 32'h00000080, "input-only pin");
		$display("pin test done");
		do_reset();
		check_dirs();
		$display("second reset test done");
		give_verdict();
	end
endmodule : pdr_regs_bench
